// [verilog/fwd_policy_map.vh]
`ifndef FWD_POLICY_MAP_VH
`define FWD_POLICY_MAP_VH

// Spanning tree port state codes
`define ST_FORWARD      2'b00
`define ST_BLOCK        2'b01
`define ST_LEARN        2'b10
`define ST_DISABLED     2'b11

// Ingress and egress port type code that enables the host tag
`define PT_HOST         2'b11

// Packet recognition values
`define ETYPE_IPV4      16'h0800
`define TPID_VLAN       16'h8100
`define IP_PROTO_IGMP   8'h02
`define VID_RESERVED    12'hFFF
`define VID_NONE        12'h000

// Special tag VID bit positions
`define TAG_PORT_LSB    0
`define TAG_LOOKUP      3
`define TAG_OVERRIDE    4
`define TAG_CALC_PRI    5
`define TAG_VLAN_RULES  6

// Frame length limits on the host port, in bytes
`define MAX_TAGGED_LEN  11'd1522
`define MAX_LONG_LEN    11'd2047

// Broadcast throttling
`define THROT_UNIT_SHIFT 6
`define THROT_INTERVAL_NS 1720000
`define CLK_PERIOD_NS   10

`endif

// [verilog/switch_forwarding_policy.v]
// Summary of operation
// [R1] Throttled ports pass at most level*64 broadcast bytes per 1.72 ms.
// [R2] With monitoring on, IGMP multicast packets go to the monitor port.
// [R3] IGMP means IPv4 protocol 2, any framing, tagged or not.
// [R4] Never send back out the receive port, optionally except IGMP.
// [R5] Monitored packets still filtered by port state and VLAN admission.
// [R6] Many ports may be mirrored, one sniffer port only.
// [R7] Receive mirroring copies packets from mirrored ports to the sniffer.
// [R8] Transmit mirroring copies packets to mirrored ports to the sniffer.
// [R9] Filtered packets are mirrored only if mirror-filtered is set.
// [R10] Software sets port type 11b on the host port, 00b elsewhere.
// [R11] Host tag bit3 clear: bits0-1 pick port or broadcast; bit4 overrides.
// [R12] Host tag bit3 set: normal lookup, learning, override from entry.
// [R13] Host tag bit5 clear uses tag priority, else content priority.
// [R14] Host tag bit6 clear skips VLAN rules, else uses second tag VID.
// [R15] The host tag is stripped on egress from destination ports.
// [R16] Host port tagged frames limited to 1522 bytes unless long frames.
// [R17] Host-bound tag carries priority, source port and IGMP flag.
// [R18] Host-bound tag bits 4-9 carry override, static, pri enable, priority.
// [R19] Bits 4-9 are zero for learned or unknown destinations.
// [R20] Host-bound tag goes ahead of any existing VLAN tag.
// [R21] Per-port count of source addresses dropped for lack of table space.
// [R22] Per-port count of ingress-filtered packets including throttle drops.
// [R23] Port state 01 blocking/listening, 10 learning, 00 forwarding.
// [R24] Counters step by one per event, read without disturbing traffic.
`timescale 1ns/10ps
`include "fwd_policy_map.vh"

module switch_forwarding_policy #(
  parameter THROT_CYCLES = `THROT_INTERVAL_NS / `CLK_PERIOD_NS,
  parameter CNT_W        = 16
) (
  input  wire                 core_clk,
  input  wire                 rstn,
  input  wire [2:0]           broadcast_throttle_config,
  input  wire [7:0]           throttle_level,
  input  wire                 igmp_monitor_en,
  input  wire [1:0]           igmp_monitor_port,
  input  wire                 igmp_own_port_en,
  input  wire                 mirror_rx_en,
  input  wire                 mirror_tx_en,
  input  wire                 mirror_filtered_en,
  input  wire [2:0]           mirror_config,
  input  wire [1:0]           sniffer_port,
  input  wire [5:0]           ingress_port_type,
  input  wire [5:0]           egress_port_type,
  input  wire [5:0]           port_state,
  input  wire [2:0]           port_ingress_config,
  input  wire [2:0]           tagged_only_admission,
  input  wire                 vlan_enable,
  input  wire                 long_frame_accept,
  input  wire                 pkt_valid,
  input  wire [1:0]           pkt_src_port,
  input  wire [10:0]          pkt_len,
  input  wire                 pkt_bcast,
  input  wire                 pkt_mcast,
  input  wire [15:0]          pkt_ethertype,
  input  wire [7:0]           pkt_ip_proto,
  input  wire                 pkt_tagged,
  input  wire [11:0]          pkt_vid,
  input  wire [2:0]           pkt_pri,
  input  wire                 pkt_inner_tagged,
  input  wire [11:0]          pkt_inner_vid,
  input  wire [2:0]           pkt_content_pri,
  input  wire                 pkt_vlan_nonmember,
  input  wire [2:0]           vlan_member_mask,
  input  wire [2:0]           lkp_dest_mask,
  input  wire                 lkp_found,
  input  wire                 lkp_static,
  input  wire                 lkp_age,
  input  wire                 lkp_pri_en,
  input  wire [2:0]           lkp_pri,
  input  wire [2:0]           learn_discard_evt,
  output reg                  dec_valid,
  output reg  [2:0]           dec_dest_mask,
  output reg                  dec_filtered,
  output reg  [2:0]           dec_priority,
  output reg                  dec_learn,
  output reg                  dec_strip_tag,
  output reg  [2:0]           dec_tag_insert,
  output reg  [31:0]          dec_host_tag,
  output reg  [3*CNT_W-1:0]   learn_discard_count,
  output reg  [3*CNT_W-1:0]   ingress_filtered_count
);

  // Decode a port number to a one-hot mask
  function [2:0] port_mask;
    input [1:0] p;
    begin
      case (p)
        2'd0:    port_mask = 3'b001;
        2'd1:    port_mask = 3'b010;
        2'd2:    port_mask = 3'b100;
        default: port_mask = 3'b000;
      endcase
    end
  endfunction

  // Pick the two-bit field of one port
  function [1:0] port_field;
    input [5:0] f;
    input [1:0] p;
    begin
      case (p)
        2'd1:    port_field = f[3:2];
        2'd2:    port_field = f[5:4];
        default: port_field = f[1:0];
      endcase
    end
  endfunction

  // Remove the receive port from a mask unless the keep flag is set
  function [2:0] strip_source;
    input [2:0] m;
    input [2:0] s;
    input       keep;
    begin
      strip_source = keep ? m : (m & ~s);
    end
  endfunction

  // Interval timer, tick pulse and per-port broadcast byte usage
  reg  [17:0] tick_cnt_q;
  reg         tick_q;
  reg  [16:0] bcast_used_q [0:2];
  integer     i;
  integer     j;
  integer     k;

  // Source port fields and host tag decode
  wire [1:0]  src_state  = port_field(port_state, pkt_src_port);
  wire [2:0]  src_mask   = port_mask(pkt_src_port);
  wire        host_in    = pkt_tagged &&
                           port_field(ingress_port_type, pkt_src_port)
                           == `PT_HOST;                           // [R10]
  wire        direct     = host_in && !pkt_vid[`TAG_LOOKUP];
  // Override comes from the tag or from the lookup entry
  wire        overr      = direct ? pkt_vid[`TAG_OVERRIDE]
                                  : (lkp_static && lkp_age);      // [R12]

  // Source port admission by spanning tree state
  wire        src_disabled = src_state == `ST_DISABLED;
  wire        src_blocked  = src_disabled ||
                             ((src_state == `ST_BLOCK ||
                               src_state == `ST_LEARN) && !overr); // [R23]

  // VLAN admission, using the inner tag behind a host tag
  wire        vlan_rules = vlan_enable &&
                           (!host_in || pkt_vid[`TAG_VLAN_RULES]); // [R14]
  // Inner tag stands in for the outer one behind a host tag
  wire        eff_tagged = host_in ? pkt_inner_tagged : pkt_tagged;
  wire [11:0] eff_vid    = host_in ? pkt_inner_vid : pkt_vid;
  wire        vlan_rej   = vlan_rules &&
                           (((!eff_tagged || eff_vid == `VID_NONE) &&
                             tagged_only_admission[pkt_src_port]) ||
                            (eff_tagged && eff_vid == `VID_RESERVED) ||
                            pkt_vlan_nonmember);                  // [R5]

  // Length check for frames entering the host port
  wire [10:0] len_limit  = long_frame_accept ? `MAX_LONG_LEN
                                             : `MAX_TAGGED_LEN;
  wire        len_err    = pkt_src_port == 2'd0 && pkt_tagged &&
                           pkt_len > len_limit;                   // [R16]

  // Broadcast allowance in bytes for this interval
  wire [16:0] allowance  = {3'b000, throttle_level, 6'b000000};
  wire [16:0] bcast_next = bcast_used_q[pkt_src_port] +
                           {6'b000000, pkt_len};
  wire        throt_drop = pkt_bcast &&
                           broadcast_throttle_config[pkt_src_port] &&
                           bcast_next > allowance;                // [R1]

  // IGMP recognition in any framing
  wire        is_igmp    = igmp_monitor_en && pkt_mcast &&
                           pkt_ethertype == `ETYPE_IPV4 &&
                           pkt_ip_proto == `IP_PROTO_IGMP;        // [R3]

  // IGMP packets may leave by their receive port when allowed
  wire        own_ok     = is_igmp && igmp_own_port_en;           // [R4]

  // Any ingress filter cause drops the packet
  wire        filtered   = src_blocked || vlan_rej ||
                           throt_drop || len_err;                 // [R5]

  // Raw destination set before state and mirror handling
  reg  [2:0]  dest_raw;
  reg  [2:0]  dest_ok;
  reg  [2:0]  fwd_mask;
  reg  [2:0]  final_mask;
  reg  [1:0]  dst_state;
  integer     d;

  // Destination selection, IGMP trap, own-port rule and mirroring
  always @* begin
    dst_state = 2'b00;
    // Host tag picks the port directly, else the lookup result
    if (direct) begin
      if (pkt_vid[1:0] == 2'd3) begin
        dest_raw = 3'b111;                                        // [R11]
      end else begin
        dest_raw = port_mask(pkt_vid[1:0]);                       // [R11]
      end
    end else begin
      dest_raw = lkp_dest_mask;                                   // [R12]
    end
    // VLAN egress membership
    if (vlan_rules) begin
      dest_raw = dest_raw & vlan_member_mask;
    end

    // Egress state filtering, overridable except for disabled ports
    for (d = 0; d < 3; d = d + 1) begin
      dst_state = port_field(port_state, d[1:0]);
      dest_ok[d] = dst_state == `ST_FORWARD ||
                   (dst_state != `ST_DISABLED && overr);          // [R11]
    end

    // IGMP trap overrides the normal destinations
    if (is_igmp) begin
      fwd_mask = port_mask(igmp_monitor_port);                    // [R2]
    end else begin
      fwd_mask = dest_raw & dest_ok;
    end
    fwd_mask = strip_source(fwd_mask, src_mask, own_ok);          // [R4]
    // Filtered packets are not forwarded
    if (filtered) begin
      fwd_mask = 3'b000;                                          // [R5]
    end
    final_mask = fwd_mask;

    // Single sniffer port receives the mirrored copies
    if (mirror_rx_en && mirror_config[pkt_src_port] &&
        (!filtered || mirror_filtered_en)) begin
      final_mask = final_mask | port_mask(sniffer_port);          // [R7] [R9]
    end
    // Transmit mirroring follows the forwarded set
    if (mirror_tx_en && |(fwd_mask & mirror_config)) begin
      final_mask = final_mask | port_mask(sniffer_port);          // [R8] [R6]
    end
    final_mask = strip_source(final_mask, src_mask, own_ok);      // [R4]
  end

  // Host-bound tag fields; bits 4 to 9 only for host-added entries
  wire        host_entry = lkp_found && lkp_static;              // [R19]
  wire [5:0]  entry_bits = host_entry ?
                           {lkp_pri, lkp_pri_en, lkp_static,
                            lkp_static && lkp_age} : 6'b000000;   // [R18]
  // Priority from the host tag or from packet contents
  wire [2:0]  pri_sel    = (host_in && !pkt_vid[`TAG_CALC_PRI]) ?
                           pkt_pri : pkt_content_pri;             // [R13]
  // Host-bound tag VID layout
  wire [11:0] host_vid   = {2'b00, entry_bits, is_igmp, 1'b0,
                            pkt_src_port};                        // [R17]
  // Ports that want the host tag on egress
  wire [2:0]  host_egress = {egress_port_type[5:4] == `PT_HOST,
                             egress_port_type[3:2] == `PT_HOST,
                             egress_port_type[1:0] == `PT_HOST};
  // Source learning admission
  wire        learn_ok   = port_ingress_config[pkt_src_port] &&
                           (src_state == `ST_FORWARD ||
                            src_state == `ST_LEARN) &&
                           !(host_in && !pkt_vid[`TAG_LOOKUP]);   // [R12]

  // A learning port still learns although its packets are discarded,
  // so only the non-state filter causes stop learning
  wire        learn_drop = vlan_rej || throt_drop || len_err;     // [R12]

  // Interval timer for broadcast throttling
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == THROT_CYCLES - 1) begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b1;                                         // [R1]
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      tick_q     <= 1'b0;
    end
  end

  // Broadcast byte usage per port, cleared each interval
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 3; i = i + 1) begin
        bcast_used_q[i] <= 17'h00000;
      end
    end else if (tick_q) begin
      for (i = 0; i < 3; i = i + 1) begin
        bcast_used_q[i] <= 17'h00000;                             // [R1]
      end
    end else if (pkt_valid && pkt_bcast && !filtered) begin
      bcast_used_q[pkt_src_port] <= bcast_next;                   // [R1]
    end
  end

  // Registered forwarding decision
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dec_valid      <= 1'b0;
      dec_dest_mask  <= 3'b000;
      dec_filtered   <= 1'b0;
      dec_priority   <= 3'b000;
      dec_learn      <= 1'b0;
      dec_strip_tag  <= 1'b0;
      dec_tag_insert <= 3'b000;
      dec_host_tag   <= 32'h00000000;
    end else begin
      dec_valid      <= pkt_valid;
      if (pkt_valid) begin
        dec_dest_mask  <= final_mask;
        dec_filtered   <= filtered;
        dec_priority   <= pri_sel;
        dec_learn      <= learn_ok && !learn_drop;                // [R12]
        dec_strip_tag  <= host_in;                                // [R15]
        dec_tag_insert <= final_mask & host_egress;               // [R17]
        dec_host_tag   <= {`TPID_VLAN, pri_sel, 1'b0, host_vid};  // [R20]
      end
    end
  end

  // Learn discard events, one wrapping count per port
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      learn_discard_count <= {3*CNT_W{1'b0}};
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        if (learn_discard_evt[j]) begin
          learn_discard_count[j*CNT_W +: CNT_W] <=
            learn_discard_count[j*CNT_W +: CNT_W] + 1'b1;         // [R21] [R24]
        end
      end
    end
  end

  // Ingress filtered packets counted against the receive port
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ingress_filtered_count <= {3*CNT_W{1'b0}};
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (pkt_valid && filtered && pkt_src_port == k) begin
          ingress_filtered_count[k*CNT_W +: CNT_W] <=
            ingress_filtered_count[k*CNT_W +: CNT_W] + 1'b1;      // [R22] [R24]
        end
      end
    end
  end

endmodule

// [verif/port_mac_model.sv]
`timescale 1ns/10ps
// Receive MAC and address lookup side, one descriptor per call
module port_mac_model (
  input  wire logic        core_clk,
  output logic             pkt_valid,
  output wire logic        pkt_bcast, pkt_mcast, pkt_tagged, lkp_found,
  output wire logic        lkp_static, lkp_age, lkp_pri_en,
  output wire logic [1:0]  pkt_src_port,
  output wire logic [2:0]  pkt_pri, pkt_content_pri, lkp_dest_mask, lkp_pri,
  output wire logic [7:0]  pkt_ip_proto,
  output wire logic [10:0] pkt_len,
  output wire logic [11:0] pkt_vid,
  output wire logic [15:0] pkt_ethertype
);
  logic [67:0] d;

  // All descriptor fields travel in one vector
  assign {pkt_bcast, pkt_mcast, pkt_tagged, lkp_found, lkp_static, lkp_age,
          lkp_pri_en, pkt_src_port, pkt_pri, pkt_content_pri, lkp_dest_mask,
          lkp_pri, pkt_ip_proto, pkt_len, pkt_vid, pkt_ethertype} = d;

  initial begin
    pkt_valid = 1'b0;
    d = '0;
  end

  // Flags f: broadcast, multicast, IGMP, tagged; lk: found, static, age, pri
  task automatic send(input [1:0] s, input [10:0] l, input [3:0] f,
                      input [11:0] v, input [2:0] dm, input [3:0] lk);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    d <= {f[3], f[2], f[0], lk, s, 3'h5, 3'h2, dm, 3'h6,
          f[1] ? 8'h02 : 8'h06, l, v, 16'h0800};
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    d <= ~d; // Fields are left inverted, not cleared, after the strobe
  endtask
endmodule

// [verif/switch_forwarding_policy_checker.sv]
`timescale 1ns/10ps
// Port relations between descriptors, decisions and counters
module switch_forwarding_policy_checker #(
  parameter CNT_W = 16
) (
  input wire logic               core_clk, rstn, pkt_valid, dec_valid,
  input wire logic               dec_filtered, mirror_filtered_en,
  input wire logic               igmp_own_port_en, lkp_found, lkp_static,
  input wire logic               lkp_age,
  input wire logic [1:0]         pkt_src_port,
  input wire logic [2:0]         dec_dest_mask, dec_tag_insert,
  input wire logic [2:0]         learn_discard_evt,
  input wire logic [5:0]         port_state, egress_port_type,
  input wire logic [31:0]        dec_host_tag,
  input wire logic [3*CNT_W-1:0] learn_discard_count, ingress_filtered_count
);
  // Source state and host egress ports
  wire [1:0]         src_st  = port_state[2*pkt_src_port +: 2];
  wire [2:0]         host_eg = {&egress_port_type[5:4],
                                &egress_port_type[3:2], &egress_port_type[1:0]};
  wire [3*CNT_W-1:0] one     = {{(3*CNT_W-1){1'b0}}, 1'b1};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_no_self_send: assert property (dec_valid && !igmp_own_port_en |->
    !dec_dest_mask[$past(pkt_src_port)]) else $error("sent to source port");
  a_filt_step: assert property (dec_valid && dec_filtered |->
    ingress_filtered_count - $past(ingress_filtered_count)
      == one << (CNT_W * $past(pkt_src_port)))
    else $error("filtered count step wrong");
  a_filt_hold: assert property (!(dec_valid && dec_filtered) |->
    $stable(ingress_filtered_count)) else $error("filtered count moved");
  a_learn_step: assert property (learn_discard_evt == 3'h4 |=>
    learn_discard_count[3*CNT_W-1:2*CNT_W]
      == $past(learn_discard_count[3*CNT_W-1:2*CNT_W]) + 1'b1)
    else $error("learn discard count step wrong");
  a_learn_hold: assert property (learn_discard_evt == 3'h0 |=>
    $stable(learn_discard_count)) else $error("learn count moved");
  a_src_disabled: assert property (pkt_valid && src_st == 2'b11
    && !mirror_filtered_en |=> dec_valid && dec_filtered
    && dec_dest_mask == 3'h0) else $error("disabled source forwarded");
  a_tag_source: assert property (dec_valid |->
    dec_host_tag[1:0] == $past(pkt_src_port)
    && dec_host_tag[31:16] == 16'h8100) else $error("host tag source wrong");
  a_tag_learned: assert property (dec_valid &&
    !$past(lkp_found && lkp_static) |-> dec_host_tag[9:4] == 6'h00)
    else $error("host tag entry bits not zero");
  a_tag_static: assert property (dec_valid &&
    $past(lkp_found && lkp_static) |-> dec_host_tag[5]
    && dec_host_tag[4] == $past(lkp_age)) else $error("host tag flags wrong");
  a_insert_host: assert property (dec_valid |->
    dec_tag_insert == (dec_dest_mask & $past(host_eg)))
    else $error("tag insert mask wrong");

  c_filtered: cover property (dec_valid && dec_filtered);
  c_insert: cover property (dec_valid && dec_tag_insert != 3'h0);
  c_learn: cover property (learn_discard_evt != 3'h0);
endmodule

bind switch_forwarding_policy switch_forwarding_policy_checker
  #(.CNT_W(CNT_W)) u_chk (.*);

// [verif/tb_switch_forwarding_policy.sv]
`timescale 1ns/10ps
module tb_switch_forwarding_policy;
  logic        core_clk, rstn, igmp_monitor_en, igmp_own_port_en, vlan_enable;
  logic        mirror_rx_en, mirror_tx_en, mirror_filtered_en;
  logic        long_frame_accept, pkt_inner_tagged, pkt_vlan_nonmember;
  logic [1:0]  igmp_monitor_port, sniffer_port;
  logic [2:0]  broadcast_throttle_config, mirror_config, port_ingress_config;
  logic [2:0]  tagged_only_admission, vlan_member_mask, learn_discard_evt;
  logic [5:0]  ingress_port_type, egress_port_type, port_state;
  logic [7:0]  throttle_level;
  logic [11:0] pkt_inner_vid;
  wire         pkt_valid, pkt_bcast, pkt_mcast, pkt_tagged, lkp_found;
  wire         lkp_static, lkp_age, lkp_pri_en, dec_valid, dec_filtered;
  wire         dec_learn, dec_strip_tag;
  wire  [1:0]  pkt_src_port;
  wire  [2:0]  pkt_pri, pkt_content_pri, lkp_dest_mask, lkp_pri;
  wire  [2:0]  dec_dest_mask, dec_priority, dec_tag_insert;
  wire  [7:0]  pkt_ip_proto;
  wire  [10:0] pkt_len;
  wire  [11:0] pkt_vid;
  wire  [15:0] pkt_ethertype;
  wire  [31:0] dec_host_tag;
  wire  [47:0] learn_discard_count, ingress_filtered_count;
  logic [15:0] fc [3];
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;

  switch_forwarding_policy #(.THROT_CYCLES(200)) dut (.*);
  port_mac_model mac (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cut a hung run short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done;
    end
  end

  task automatic chk(input string nm, input [47:0] got, input [47:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One descriptor, then the decision and the filtered count
  task automatic pk(input [1:0] s, input [10:0] l, input [3:0] f,
                    input [11:0] v, input [2:0] dm, input [3:0] lk,
                    input [2:0] em, input ef);
    mac.send(s, l, f, v, dm, lk);
    #1;
    if (ef) fc[s] = fc[s] + 16'h1;
    chk("valid", dec_valid, 1'b1);
    chk("mask", dec_dest_mask, em);
    chk("filt", dec_filtered, ef);
    chk("fcnt", ingress_filtered_count[16*s +: 16], fc[s]);
  endtask

  task automatic t_throttle;
    broadcast_throttle_config <= 3'h2;
    throttle_level <= 8'h02;
    repeat (2) pk(2'h1, 11'd64, 4'h8, 12'h0, 3'h7, 4'h0, 3'h5, 1'b0);
    pk(2'h1, 11'd64, 4'h8, 12'h0, 3'h7, 4'h0, 3'h0, 1'b1);
    repeat (205) @(posedge core_clk);
    pk(2'h1, 11'd64, 4'h8, 12'h0, 3'h7, 4'h0, 3'h5, 1'b0);
    broadcast_throttle_config <= 3'h0;
  endtask

  task automatic t_filter;
    for (int i = 1; i < 4; i++) begin
      @(posedge core_clk);
      port_state <= 6'(i << 2);
      pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h4, 4'h0, 3'h0, 1'b1);
    end
    @(posedge core_clk);
    port_state <= 6'h04;
    pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h4, 4'hE, 3'h4, 1'b0);
    @(posedge core_clk);
    port_state <= 6'h00;
    vlan_enable <= 1'b1;
    pk(2'h2, 11'd100, 4'h1, 12'hFFF, 3'h1, 4'h0, 3'h0, 1'b1);
    pk(2'h2, 11'd100, 4'h1, 12'h005, 3'h1, 4'h0, 3'h1, 1'b0);
    vlan_enable <= 1'b0;
    pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h6, 4'h0, 3'h4, 1'b0);
  endtask

  task automatic t_mirror;
    mirror_rx_en <= 1'b1;
    mirror_config <= 3'h4;
    pk(2'h2, 11'd100, 4'h0, 12'h0, 3'h2, 4'h0, 3'h3, 1'b0);
    pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h4, 4'h0, 3'h4, 1'b0);
    mirror_rx_en <= 1'b0;
    mirror_tx_en <= 1'b1;
    pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h4, 4'h0, 3'h5, 1'b0);
    pk(2'h0, 11'd100, 4'h0, 12'h0, 3'h4, 4'h0, 3'h4, 1'b0);
    mirror_tx_en <= 1'b0;
    mirror_rx_en <= 1'b1;
    port_state <= 6'h10;
    pk(2'h2, 11'd100, 4'h0, 12'h0, 3'h2, 4'h0, 3'h0, 1'b1);
    mirror_filtered_en <= 1'b1;
    pk(2'h2, 11'd100, 4'h0, 12'h0, 3'h2, 4'h0, 3'h1, 1'b1);
    {mirror_rx_en, mirror_filtered_en, port_state} <= '0;
  endtask

  task automatic t_igmp;
    igmp_monitor_en <= 1'b1;
    egress_port_type <= 6'h03;
    pk(2'h1, 11'd80, 4'h6, 12'h0, 3'h6, 4'h0, 3'h1, 1'b0);
    chk("ins", dec_tag_insert, 3'h1);
    chk("tag", dec_host_tag[11:0], 12'h009);
    pk(2'h2, 11'd80, 4'h7, 12'h005, 3'h3, 4'h0, 3'h1, 1'b0);
    igmp_monitor_port <= 2'h1;
    igmp_own_port_en <= 1'b1;
    pk(2'h1, 11'd80, 4'h6, 12'h0, 3'h4, 4'h0, 3'h2, 1'b0);
    pk(2'h1, 11'd80, 4'h4, 12'h0, 3'h6, 4'h0, 3'h4, 1'b0);
    {igmp_monitor_en, igmp_own_port_en} <= 2'h0;
  endtask

  task automatic t_host_in;
    ingress_port_type <= 6'h03;
    egress_port_type <= 6'h00;
    pk(2'h0, 11'd100, 4'h1, 12'h002, 3'h2, 4'h0, 3'h4, 1'b0);
    chk("strip", dec_strip_tag, 1'b1);
    chk("pri", dec_priority, 3'h5);
    chk("lrn", dec_learn, 1'b0);
    pk(2'h0, 11'd100, 4'h1, 12'h003, 3'h0, 4'h0, 3'h6, 1'b0);
    pk(2'h0, 11'd100, 4'h1, 12'h028, 3'h2, 4'h0, 3'h2, 1'b0);
    chk("pri", dec_priority, 3'h2);
    chk("lrn", dec_learn, 1'b1);
    port_state <= 6'h10;
    pk(2'h0, 11'd100, 4'h1, 12'h002, 3'h0, 4'h0, 3'h0, 1'b0);
    pk(2'h0, 11'd100, 4'h1, 12'h012, 3'h0, 4'h0, 3'h4, 1'b0);
    port_state <= 6'h12;
    pk(2'h0, 11'd100, 4'h1, 12'h028, 3'h2, 4'h0, 3'h0, 1'b1);
    chk("lrn", dec_learn, 1'b1);
    port_state <= 6'h00;
    pk(2'h0, 11'd1522, 4'h1, 12'h002, 3'h0, 4'h0, 3'h4, 1'b0);
    pk(2'h0, 11'd1523, 4'h1, 12'h002, 3'h0, 4'h0, 3'h0, 1'b1);
    long_frame_accept <= 1'b1;
    pk(2'h0, 11'd1523, 4'h1, 12'h002, 3'h0, 4'h0, 3'h4, 1'b0);
    ingress_port_type <= 6'h00;
  endtask

  task automatic t_host_out;
    egress_port_type <= 6'h03;
    pk(2'h2, 11'd100, 4'h0, 12'h0, 3'h1, 4'hF, 3'h1, 1'b0);
    chk("ins", dec_tag_insert, 3'h1);
    chk("tag", dec_host_tag[11:0], 12'h372);
    pk(2'h2, 11'd100, 4'h0, 12'h0, 3'h1, 4'hB, 3'h1, 1'b0);
    chk("tag", dec_host_tag[11:0], 12'h002);
    pk(2'h1, 11'd100, 4'h0, 12'h0, 3'h1, 4'h0, 3'h1, 1'b0);
    chk("tag", dec_host_tag[11:0], 12'h001);
  endtask

  task automatic t_counts;
    repeat (2) begin
      @(posedge core_clk);
      learn_discard_evt <= 3'h4;
      @(posedge core_clk);
      learn_discard_evt <= 3'h0;
    end
    @(posedge core_clk);
    #1;
    chk("lcnt", learn_discard_count, {16'h2, 32'h0});
  endtask

  task test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset, then scenarios
  initial begin
    rstn = 1'b0;
    fc = '{default: 16'h0};
    {igmp_monitor_en, igmp_own_port_en, vlan_enable, mirror_rx_en} = '0;
    {mirror_tx_en, mirror_filtered_en, long_frame_accept} = '0;
    {pkt_inner_tagged, pkt_vlan_nonmember, pkt_inner_vid} = '0;
    {igmp_monitor_port, sniffer_port, broadcast_throttle_config} = '0;
    {mirror_config, tagged_only_admission, learn_discard_evt} = '0;
    {ingress_port_type, egress_port_type, port_state, throttle_level} = '0;
    port_ingress_config = 3'h7;
    vlan_member_mask = 3'h7;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_throttle;
    t_filter;
    t_mirror;
    t_igmp;
    t_host_in;
    t_host_out;
    t_counts;
    test_done;
  end
endmodule
